// ### hw/ps_consts.svh
// Constants of the programmable threshold stage: scales, defaults, timing.
// Assumes a 250 MHz core clock and a 5 ms program-cycle tick.
// Functional notes
// - Watch one to three measurements, each against its own pick-up level.
// - Multiply each measurement by its multiplier; output the scaled value.
// - Output live ratio of each scaled value to its pick-up level.
// - Output live ratio of the combined magnitude to its pick-up level.
// - Hysteresis is a percentage of pick-up in 0.0001 % steps.
// - Each comparison has its own hysteresis, default 3 %.
// - Eight comparator modes per comparison, default plain over.
// - Over: signed value above pick-up.
// - Absolute over: magnitude above pick-up.
// - Under: signed value below pick-up.
// - Absolute under: magnitude below pick-up.
// - Under modes are disabled while value lies below the blocking limit.
// - Directional relative change beyond set percent within 20 ms.
// - Relative change beyond set percent within 20 ms, either way.
// - Directional change beyond set amount within 20 ms.
// - Change beyond set amount within 20 ms, either way.
// - Signed pick-up levels, resolution 0.0001, default 0.01.
// - Trip after definite operate delay, 5 ms steps, default 0.04 s.
// - Release delay after pick-up drops, default 0.06 s.
// - Status is normal, start, trip or blocked.
// - Count down and output time left to trip.
// - Output the expected operating time.
// - Blocking at pick-up gives blocked; blocking during start releases it.
`ifndef PS_CONSTS_SVH
`define PS_CONSTS_SVH
`define PS_CLK_NS        4
`define PS_TICK_NS       5000000
`define PS_TICK_CYCLES   (`PS_TICK_NS / `PS_CLK_NS)
`define PS_WIN_NS        20000000
`define PS_WIN_TICKS     (`PS_WIN_NS / `PS_TICK_NS)
`define PS_FIX_ONE       10000
`define PS_PCT_SCALE     1000000
`define PS_PICKUP_DEF    100
`define PS_HYST_DEF      30000
`define PS_MULT_DEF      10000
`define PS_OP_DELAY_NS   40000000
`define PS_REL_DELAY_NS  60000000
`define PS_OP_DELAY_DEF  (`PS_OP_DELAY_NS / `PS_TICK_NS)
`define PS_REL_DELAY_DEF (`PS_REL_DELAY_NS / `PS_TICK_NS)
`define PS_MAX_DELAY     360000
`endif

// ### hw/ps_pkg.sv
// Types shared by the programmable threshold stage and its users.
// Values are signed fixed point with 0.0001 resolution.
package ps_pkg;
  typedef logic signed [31:0] ps_val_t;
  typedef logic [18:0]        ps_ticks_t;
  typedef enum logic [2:0] {
    PS_OVER      = 3'h0,
    PS_OVER_ABS  = 3'h1,
    PS_UNDER     = 3'h2,
    PS_UNDER_ABS = 3'h3,
    PS_DREL_DIR  = 3'h4,
    PS_DREL_ABS  = 3'h5,
    PS_DVAL_DIR  = 3'h6,
    PS_DVAL_ABS  = 3'h7
  } ps_mode_t;
  typedef enum logic [1:0] {
    PS_NORMAL  = 2'h0,
    PS_START   = 2'h1,
    PS_TRIP    = 2'h2,
    PS_BLOCKED = 2'h3
  } ps_status_t;
  typedef struct packed {
    ps_mode_t    mode;
    ps_val_t     pickup;
    logic [18:0] hyst;
    ps_val_t     mult;
    logic        blk_en;
    ps_val_t     blk_lim;
  } ps_chan_cfg_t;
  typedef struct packed {
    ps_ticks_t op_delay;
    ps_ticks_t rel_delay;
  } ps_timing_t;
endpackage

// ### hw/ps_stage.sv
// Programmable threshold stage: scaling, comparison, operate/release timing.
// Inputs are synchronous to core_clk; settings are held steady by the user.
`include "ps_consts.svh"
module ps_stage #(
  parameter int TICK_CYCLES = `PS_TICK_CYCLES,
  parameter int WIN_TICKS   = `PS_WIN_TICKS
) (
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  // Settings
  input  wire ps_pkg::ps_chan_cfg_t [2:0] chan_cfg,
  input  wire logic [1:0]              chan_count,
  input  wire ps_pkg::ps_val_t         calc_pickup,
  input  wire ps_pkg::ps_timing_t      timing,
  // Measurements and blocking
  input  wire ps_pkg::ps_val_t [2:0]   meas,
  input  wire logic                    block_in,
  // Live values
  output ps_pkg::ps_val_t [2:0]        scaled_mag,
  output ps_pkg::ps_val_t [2:0]        measured_to_pickup_ratio,
  output ps_pkg::ps_val_t              calculated_to_pickup_ratio,
  // Stage state
  output ps_pkg::ps_status_t           status,
  output logic                         stage_start,
  output logic                         stage_trip,
  output logic                         stage_blocked,
  output ps_pkg::ps_ticks_t            time_remaining,
  output ps_pkg::ps_ticks_t            expected_time
);
  import ps_pkg::*;

  localparam logic signed [63:0] FIX1 = 64'sd`PS_FIX_ONE;
  localparam logic signed [63:0] PCT  = 64'sd`PS_PCT_SCALE;

  // Saturate to 32-bit signed
  function automatic ps_val_t sat32(input logic signed [63:0] v);
    if (v > 64'sh7FFFFFFF)
      return 32'sh7FFFFFFF;
    if (v < -64'sh80000000)
      return 32'sh80000000;
    return ps_val_t'(v);
  endfunction

  // a*b/c in 64 bits; zero when c is zero
  function automatic logic signed [63:0] mul_div(
    input logic signed [63:0] a,
    input logic signed [63:0] b,
    input logic signed [63:0] c);
    if (c == 64'sh0)
      return 64'sh0;
    return (a * b) / c;
  endfunction

  function automatic logic signed [63:0] abs64(input logic signed [63:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // Program-cycle tick divider
  logic [31:0] tdiv_reg, tdiv_next;
  logic        tick_reg, tick_next;
  always_comb
  begin
    tick_next = 1'b0;
    tdiv_next = tdiv_reg + 32'h1;
    if (tdiv_reg >= 32'(TICK_CYCLES - 1))
    begin
      tdiv_next = 32'h0;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdiv_reg <= 32'h0;
      tick_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      tdiv_reg <= tdiv_next;
      tick_reg <= tick_next;
    end
  end

  // Scaling, ratios, change window and comparisons
  ps_val_t [2:0] scl_reg, scl_next, rat_reg, rat_next;
  ps_val_t       crat_reg, crat_next;
  ps_val_t       hist_reg [3][WIN_TICKS];
  ps_val_t       hist_next [3][WIN_TICKS];
  logic [2:0]    cond_reg, cond_next;
  logic signed [63:0] x, d, m, t, band, csum;
  logic          over;
  always_comb
  begin
    csum = 64'sh0;
    x = 64'sh0;
    d = 64'sh0;
    m = 64'sh0;
    t = 64'sh0;
    band = 64'sh0;
    over = 1'b1;
    hist_next = hist_reg;
    cond_next = cond_reg;
    for (int i = 0; i < 3; i++)
    begin
      scl_next[i] = sat32(mul_div(meas[i], chan_cfg[i].mult, FIX1));
      rat_next[i] = sat32(mul_div(scl_reg[i], FIX1,
                                  chan_cfg[i].pickup));
      if (i < chan_count)
        csum = csum + scl_reg[i];
      x = scl_reg[i];
      d = x - hist_reg[i][WIN_TICKS-1];
      t = chan_cfg[i].pickup;
      band = mul_div(abs64(t), 64'(chan_cfg[i].hyst), PCT);
      over = 1'b1;
      unique case (chan_cfg[i].mode)
        PS_OVER:      m = x;
        PS_OVER_ABS:  m = abs64(x);
        PS_UNDER:
        begin
          m = x;
          over = 1'b0;
        end
        PS_UNDER_ABS:
        begin
          m = abs64(x);
          over = 1'b0;
        end
        PS_DREL_DIR:
        begin
          m = (t < 0) ? -d : d;
          t = mul_div(abs64(hist_reg[i][WIN_TICKS-1]), abs64(t), PCT);
        end
        PS_DREL_ABS:
        begin
          m = abs64(d);
          t = mul_div(abs64(hist_reg[i][WIN_TICKS-1]), abs64(t), PCT);
        end
        PS_DVAL_DIR:
        begin
          m = (t < 0) ? -d : d;
          t = abs64(t);
        end
        PS_DVAL_ABS:
        begin
          m = abs64(d);
          t = abs64(t);
        end
      endcase
      if (tick_reg)
      begin
        // Held conditions release past the band, or when the blocking limit or the channel count clears them
        if (over)
          cond_next[i] = m > (cond_reg[i] ? t - band : t);
        else
          cond_next[i] = m < (cond_reg[i] ? t + band : t);
        if (!over && chan_cfg[i].blk_en && x < chan_cfg[i].blk_lim)
          cond_next[i] = 1'b0;
        if (i >= chan_count)
          cond_next[i] = 1'b0;
        hist_next[i][0] = scl_reg[i];
        for (int k = 1; k < WIN_TICKS; k++)
          hist_next[i][k] = hist_reg[i][k-1];
      end
    end
    crat_next = sat32(mul_div(csum, FIX1, calc_pickup));
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_reg  <= '0;
      rat_reg  <= '0;
      crat_reg <= '0;
      cond_reg <= 3'h0;
      for (int i = 0; i < 3; i++)
        for (int k = 0; k < WIN_TICKS; k++)
          hist_reg[i][k] <= 32'sh0;
    end
    else if (clk_en)
    begin
      scl_reg  <= scl_next;
      rat_reg  <= rat_next;
      crat_reg <= crat_next;
      cond_reg <= cond_next;
      hist_reg <= hist_next;
    end
  end

  // Operate and release timing; blocking taken at each tick
  ps_status_t st_reg, st_next;
  ps_ticks_t  op_reg, op_next, rel_reg, rel_next, rem_reg, rem_next;
  ps_ticks_t  exp_reg;
  logic       pickup, eff;
  logic       start_reg, start_next, trip_reg, trip_next;
  logic       blk_reg, blk_next;
  always_comb
  begin
    pickup = |cond_reg;
    eff = pickup && !block_in;
    st_next = st_reg;
    op_next = op_reg;
    rel_next = rel_reg;
    if (tick_reg)
    begin
      unique case (st_reg)
        PS_NORMAL:
          if (pickup)
          begin
            st_next = block_in ? PS_BLOCKED : PS_START;
            op_next = '0;
            rel_next = '0;
          end
        PS_BLOCKED:
          if (!pickup)
            st_next = PS_NORMAL;
          else if (!block_in)
          begin
            st_next = PS_START;
            op_next = '0;
          end
        PS_START, PS_TRIP:
          if (eff)
          begin
            rel_next = '0;
            if (st_reg == PS_START)
            begin
              op_next = op_reg + 19'h1;
              if (op_reg + 19'h1 >= timing.op_delay)
                st_next = PS_TRIP;
            end
          end
          else if (rel_reg + 19'h1 >= timing.rel_delay)
          begin
            // Blocking mid-start ends through release timing
            st_next = pickup ? PS_BLOCKED : PS_NORMAL;
            op_next = '0;
            rel_next = '0;
          end
          else
            rel_next = rel_reg + 19'h1;
      endcase
    end
    rem_next = '0;
    if (st_next == PS_START)
      rem_next = (timing.op_delay > op_next) ?
                 timing.op_delay - op_next : '0;
    // Flags decoded one state ahead so each output leaves a flop
    start_next = (st_next == PS_START) || (st_next == PS_TRIP);
    trip_next  = (st_next == PS_TRIP);
    blk_next   = (st_next == PS_BLOCKED);
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg  <= PS_NORMAL;
      op_reg  <= '0;
      rel_reg <= '0;
      rem_reg <= '0;
      exp_reg <= '0;
      start_reg <= 1'b0;
      trip_reg  <= 1'b0;
      blk_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      st_reg  <= st_next;
      op_reg  <= op_next;
      rel_reg <= rel_next;
      rem_reg <= rem_next;
      exp_reg <= timing.op_delay;
      start_reg <= start_next;
      trip_reg  <= trip_next;
      blk_reg   <= blk_next;
    end
  end

  assign scaled_mag = scl_reg;
  assign measured_to_pickup_ratio = rat_reg;
  assign calculated_to_pickup_ratio = crat_reg;
  assign status = st_reg;
  assign stage_start = start_reg;
  assign stage_trip = trip_reg;
  assign stage_blocked = blk_reg;
  assign time_remaining = rem_reg;
  assign expected_time = exp_reg;

  // Checks on the stage behaviour
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_TRIP_FROM_START:
    assert property ($rose(stage_trip) |-> $past(st_reg) == PS_START)
    else $error("trip did not follow start");
  AST_BLOCK_AT_PICKUP:
    assert property (clk_en && tick_reg && st_reg == PS_NORMAL && pickup
                     && block_in |=> stage_blocked && !stage_start)
    else $error("pickup under block did not give blocked");
  AST_START_AT_PICKUP:
    assert property (clk_en && tick_reg && st_reg == PS_NORMAL && pickup
                     && !block_in |=> st_reg == PS_START)
    else $error("pickup did not give start");
  AST_REMAIN_BOUND:
    assert property (st_reg == PS_START |->
                     rem_reg + op_reg == timing.op_delay
                     || timing.op_delay <= op_reg)
    else $error("time remaining inconsistent");
  AST_EXPECTED_TIME:
    assert property (reset_n && clk_en
                     |=> expected_time == $past(timing.op_delay))
    else $error("expected time does not follow delay");
  AST_TRIP_HOLDS:
    assert property (stage_trip && clk_en && tick_reg && eff |=> stage_trip)
    else $error("trip dropped while condition held");
  AST_ZERO_PICKUP_RATIO:
    assert property (clk_en && chan_cfg[0].pickup == 32'sh0
                     |=> measured_to_pickup_ratio[0] == 32'sh0)
    else $error("ratio not zero for zero pickup");
  AST_UNITY_SCALE:
    assert property (clk_en && chan_cfg[0].mult == `PS_FIX_ONE
                     |=> scaled_mag[0] == $past(meas[0]))
    else $error("unity multiplier changed the value");
  AST_TICK_SPACING:
    assert property (TICK_CYCLES > 1 && clk_en && tick_reg |=> !tick_reg)
    else $error("ticks too close");
endmodule

// ### tb/ps_meas_src.sv
// Measurement engine model feeding the threshold stage.
// Assumes the bench sets targets; slow mode refreshes every third cycle.
module ps_meas_src
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // Bench control
  input  wire logic                slow,
  input  wire ps_pkg::ps_val_t [2:0] target,
  // Samples towards the stage
  output ps_pkg::ps_val_t [2:0]      meas
);
  timeunit 1ns;
  timeprecision 1ps;
  import ps_pkg::*;
  logic [1:0]    div_reg, div_next;
  ps_val_t [2:0] meas_reg, meas_next;

  // Slow engine holds old samples, so the stage sees late updates
  always_comb
  begin
    div_next  = (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    meas_next = (!slow || div_reg == 2'h0) ? target : meas_reg;
  end

  // Sample registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg  <= 2'h0;
      meas_reg <= '0;
    end
    else
    begin
      div_reg  <= div_next;
      meas_reg <= meas_next;
    end
  end

  assign meas = meas_reg;
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the threshold stage and its measurement source.
// Assumes a short tick and window; expectations come from bench functions.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ps_pkg::*;
  localparam int     TK  = 4;
  localparam longint ONE = 64'h2710;
  logic               core_clk = 1'b0;
  logic               reset_n  = 1'b0;
  logic               clk_en, block_in, slow, seen;
  logic               stage_start, stage_trip, stage_blocked;
  logic [1:0]         chan_count;
  ps_chan_cfg_t [2:0] chan_cfg;
  ps_val_t            calc_pickup, calculated_to_pickup_ratio;
  ps_timing_t         timing;
  ps_val_t [2:0]      target, meas, scaled_mag, measured_to_pickup_ratio;
  ps_status_t         status;
  ps_ticks_t          time_remaining, expected_time;
  ps_mode_t           md;
  int                 err_total = 0;
  int                 checks = 0;
  int                 seed = 12223;
  int                 n, p, m;
  longint             e, sum, r;

  // Core clock, 4 ns period
  always #2 core_clk = ~core_clk;

  ps_meas_src src (.core_clk, .reset_n, .slow, .target, .meas);
  ps_stage #(.TICK_CYCLES(TK), .WIN_TICKS(4)) dut (
    .core_clk, .reset_n, .clk_en, .chan_cfg, .chan_count, .calc_pickup,
    .timing, .meas, .block_in, .scaled_mag, .measured_to_pickup_ratio,
    .calculated_to_pickup_ratio, .status, .stage_start, .stage_trip,
    .stage_blocked, .time_remaining, .expected_time);

  task automatic give_verdict();
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen_v, exp_v);
    end
  endtask

  // Bounded wait for a status; running out ends the run
  task automatic wait_st(input ps_status_t st, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (status !== st)
    begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (cnt > lim)
      begin
        err_total++;
        give_verdict();
      end
    end
  endtask

  function automatic ps_chan_cfg_t mk(input ps_mode_t d, input int pu,
                                      input int mu);
    return '{d, pu, 19'h7530, mu, 1'b0, 32'h0};
  endfunction

  // Live values clip at the signed 32-bit top
  function automatic longint sat(input longint v);
    if (v > 64'sh7FFFFFFF)
      return 64'sh7FFFFFFF;
    return v;
  endfunction

  function automatic logic cond_of(input ps_mode_t d, input int mv,
                                   input int pu);
    int a;
    a = (mv < 0) ? -mv : mv;
    case (d)
      PS_OVER:     return mv > pu;
      PS_OVER_ABS: return a > pu;
      PS_UNDER:    return mv < pu;
      default:     return a < pu;
    endcase
  endfunction

  // Stop comparing, park the source, let the window history settle
  task automatic idle(input int mv);
    @(posedge core_clk);
    chan_count <= 2'h0;
    block_in   <= 1'b0;
    target[0]  <= mv;
    wait_st(PS_NORMAL, 200, n);
    repeat (6 * TK) @(posedge core_clk);
  endtask

  // Enable the channel two cycles on, when its scaled value is fresh unless the source is slow,
  // so no tick compares a stale sample against the new setting
  task automatic go(input ps_mode_t d, input int pu, input int mv);
    @(posedge core_clk);
    chan_cfg[0] <= mk(d, pu, 32'h2710);
    target[0]   <= mv;
    repeat (2) @(posedge core_clk);
    chan_count  <= 2'h1;
  endtask

  initial
  begin
    clk_en      = 1'b1;
    block_in    = 1'b0;
    slow        = 1'b0;
    chan_count  = 2'h0;
    chan_cfg    = '0;
    calc_pickup = 32'h2710;
    target      = '0;
    timing      = '{19'h40, 19'h1};
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    // Scaling and live ratios, random values and channel count
    repeat (8)
    begin
      @(posedge core_clk);
      chan_count  <= 2'($random(seed));
      calc_pickup <= ($random(seed) & 32'hFFFF) + 1;
      for (int i = 0; i < 3; i++)
      begin
        target[i]   <= $random(seed) & 32'hFFFF;
        chan_cfg[i] <= mk(PS_OVER, ($random(seed) & 32'hFFFF) + 1,
                          ($random(seed) & 32'h3FFF) + 1);
      end
      repeat (4) @(posedge core_clk);
      #1;
      sum = 0;
      for (int i = 0; i < 3; i++)
      begin
        e = sat(longint'(target[i]) * chan_cfg[i].mult / ONE);
        check(scaled_mag[i], e);
        r = sat(e * ONE / chan_cfg[i].pickup);
        check(measured_to_pickup_ratio[i], r);
        if (i < chan_count)
          sum += e;
      end
      r = sat(sum * ONE / calc_pickup);
      check(calculated_to_pickup_ratio, r);
    end
    // Clock enable low freezes the live values
    @(posedge core_clk);
    clk_en    <= 1'b0;
    target[2] <= target[2] + 32'h10000;
    repeat (4) @(posedge core_clk);
    #1;
    check(scaled_mag[2], e);
    @(posedge core_clk);
    clk_en <= 1'b1;
    // Plain and absolute comparisons from a quiet stage
    repeat (16)
    begin
      md = ps_mode_t'($random(seed) & 3);
      p  = $random(seed) >>> 17;
      m  = $random(seed) >>> 17;
      // Park the source on the new value first
      idle(m);
      slow <= 1'($random(seed));
      go(md, p, m);
      repeat (6 * TK) @(posedge core_clk);
      #1;
      seen = cond_of(md, m, p);
      check(stage_start, seen);
    end
    check(expected_time, 19'h40);
    // Operate delay and countdown
    idle(0);
    timing <= '{19'h3, 19'h2};
    go(PS_OVER, 32'h2710, 32'h4E20);
    wait_st(PS_START, 40, n);
    check(time_remaining, 19'h3);
    repeat (TK) @(posedge core_clk);
    #1;
    check(time_remaining, 19'h2);
    wait_st(PS_TRIP, 40, n);
    check(n, 2 * TK);
    // Inside the 3 % band the trip holds, below it release runs
    @(posedge core_clk);
    target[0] <= 32'h2648;
    repeat (10 * TK) @(posedge core_clk);
    #1;
    check(stage_trip, 1'b1);
    @(posedge core_clk);
    target[0] <= 32'h2580;
    wait_st(PS_NORMAL, 40, n);
    check(n >= 2 * TK && n <= 5 * TK, 1'b1);
    // Blocking at pick-up, lifted, then applied during start
    idle(0);
    block_in <= 1'b1;
    go(PS_OVER, 32'h2710, 32'h4E20);
    wait_st(PS_BLOCKED, 40, n);
    check(stage_start, 1'b0);
    @(posedge core_clk);
    block_in <= 1'b0;
    wait_st(PS_START, 40, n);
    check(stage_blocked, 1'b0);
    @(posedge core_clk);
    block_in <= 1'b1;
    wait_st(PS_BLOCKED, 40, n);
    // Block is taken at the next tick, the first of two release ticks
    check(n, 2 * TK - 1);
    // Under comparison idle beneath its blocking limit
    idle(0);
    chan_cfg[0] <= '{PS_UNDER, 32'h2710, 19'h7530, 32'h2710, 1'b1, 32'h3E8};
    target[0]   <= 32'h1F4;
    chan_count  <= 2'h1;
    repeat (6 * TK) @(posedge core_clk);
    #1;
    check(stage_start, 1'b0);
    @(posedge core_clk);
    target[0] <= 32'h7D0;
    wait_st(PS_START, 40, n);
    // Change-over-window modes with rising and falling steps
    for (int k = 0; k < 8; k++)
    begin
      md = ps_mode_t'(3'h4 + k[1:0]);
      idle(32'h2710);
      go(md, md[1] ? 32'h3E8 : 32'h186A0, k[2] ? 32'h1388 : 32'h3A98);
      seen = 1'b0;
      repeat (8 * TK)
      begin
        @(posedge core_clk);
        #1;
        seen |= stage_start;
      end
      check(seen, !k[2] || md[0]);
    end
    give_verdict();
  end
endmodule
